/* File: rtl/serial_shift_in.sv */
// Purpose: Three-wire serial receiver: shift register and load strobe.
// Assumes: Pins are asynchronous to clk; serial clock at most half of clk.
// Notes: Emits a one-cycle word_valid on each rising load strobe.
`default_nettype none

module serial_shift_in
  import synth_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic serial_clk_pin,
  input wire logic serial_data_pin,
  input wire logic load_strobe_pin,
  // Received word
  output logic [WORD_BITS-1:0] word,
  output logic word_valid
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] meta_reg, meta_next;
  logic [2:0] sync_reg, sync_next;
  logic [2:0] prev_reg, prev_next;
  logic [WORD_BITS-1:0] shift_reg, shift_next;
  logic valid_reg, valid_next;
  logic sclk_rise, load_rise;

  always_comb begin
    meta_next = {load_strobe_pin, serial_data_pin, serial_clk_pin};
    sync_next = meta_reg;
    prev_next = sync_reg;
    sclk_rise = sync_reg[0] && !prev_reg[0];
    load_rise = sync_reg[2] && !prev_reg[2];
    shift_next = shift_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[WORD_BITS-2:0], sync_reg[1]};
    end
    valid_next = load_rise;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
      shift_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      shift_reg <= shift_next;
      valid_reg <= valid_next;
    end
  end

  assign word = shift_reg;
  assign word_valid = valid_reg;

  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!rst_n)
    sclk_rise |=> shift_reg == {$past(shift_reg[WORD_BITS-2:0]), $past(sync_reg[1])})
    else $error("serial bit not shifted in on clock rise");

endmodule

`default_nettype wire

/* File: rtl/synth_pkg.sv */
// Purpose: Shared constants for the synthesizer serial latch bank.
// Assumes: 24-bit words, most significant bit first, two select bits at 1:0.
// Notes: Field positions not fixed elsewhere are collected here.
`default_nettype none

package synth_pkg;

  // ****************************************************************
  // Word format
  // ****************************************************************
  localparam int WORD_BITS = 24;
  localparam int SEL_LSB = 0;
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_FEEDBACK = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;

  // ****************************************************************
  // Control word latch fields
  // ****************************************************************
  localparam int CORE_POWER_LSB = 2;
  localparam int COUNTER_RESET_BIT = 4;
  localparam int MUX_SEL_LSB = 5;
  localparam int PHASE_POL_BIT = 8;
  localparam int CP_TRISTATE_BIT = 9;
  localparam int CTRL_CP_GAIN_BIT = 10;

  // ****************************************************************
  // Feedback and reference divider latch fields
  // ****************************************************************
  localparam int FB_COUNT_LSB = 8;
  localparam int FB_COUNT_W = 13;
  localparam int FB_CP_GAIN_BIT = 21;
  localparam int REF_COUNT_LSB = 2;
  localparam int REF_COUNT_W = 14;
  localparam int ABP_LSB = 16;
  localparam int LOCK_PREC_BIT = 18;
  localparam int TEST_SEL_BIT = 19;
  localparam int BAND_DIV_LSB = 20;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [23:0] CTRL_RESET = 24'h000010;
  localparam logic [23:0] FB_RESET = 24'h000302;
  localparam logic [23:0] REF_RESET = 24'h000005;
  localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
  localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;

  // ****************************************************************
  // Multiplexed output selections
  // ****************************************************************
  localparam logic [2:0] MUX_LOW = 3'h0;
  localparam logic [2:0] MUX_LOCK = 3'h1;
  localparam logic [2:0] MUX_REF_DIV = 3'h2;
  localparam logic [2:0] MUX_FB_DIV = 3'h3;
  localparam logic [2:0] MUX_BAND_CLK = 3'h4;
  localparam logic [2:0] MUX_HIGH = 3'h5;
  localparam logic [2:0] MUX_HELD = 3'h6;

endpackage

`default_nettype wire

/* File: rtl/synth_serial_latch_bank.sv */
// Purpose: Latch bank of an integer-N synthesizer, loaded over three wires.
// Assumes: Reference and feedback edges arrive as slow pins sampled at 40 MHz.
// Notes: Analog controls leave as registered levels; counters run on clk.
`default_nettype none

// Contract
// - Three-state bit at 1 floats the charge pump output; 0 is normal.
// - Polarity bit 1 selects positive phase detector polarity, 0 negative.
// - Three-bit mux field picks the signal on the multiplexed output pin.
// - Counter reset bit 4 at 1 holds reference and feedback counters reset.
// - Two-bit core power field sets oscillator core current; 5 mA advised.
// - Thirteen-bit feedback count divides the loop, valid range 3 to 8191.
// - Feedback division ratio equals the feedback count alone, no prescaler.
// - Feedback latch bit 21 selects charge pump current setting 2 or 1.
// - Charge pump gain follows the latest write via control or feedback latch.
// - Select code (0,1) loads the reference divider latch.
// - Fourteen-bit reference count divides the reference, range 1 to 16383.
// - Reference latch bits 16 and 17 set antibacklash pulse width.
// - Lock after five good reference cycles if precision bit set, else three.
// - Factory test bit cleared means test latch is ignored.
// - Band select clock is reference divider output, optionally divided further.
// - One bit shifts in per serial clock rise; strobe rise loads 24 bits.
// - Select code (0,0) loads the control word latch.
module synth_serial_latch_bank
  import synth_pkg::*;
#(
  parameter int REF_W = REF_COUNT_W,
  parameter int FB_W = FB_COUNT_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial interface pins
  input wire logic serial_clk_pin,
  input wire logic serial_data_pin,
  input wire logic load_strobe_pin,
  // Loop pins
  input wire logic ref_in_pin,
  input wire logic vco_fb_pin,
  input wire logic phase_ok_pin,
  // Charge pump and phase detector
  output logic cp_out_oe,
  output logic phase_polarity_sel,
  output logic cp_gain_sel,
  output logic [1:0] antibacklash_width_field,
  // Oscillator and test
  output logic [1:0] core_power_field,
  output logic factory_test_sel,
  // Loop status
  output logic ref_div_pulse,
  output logic fb_div_pulse,
  output logic band_clk_en,
  output logic lock_detect,
  output logic multiplexed_output_pin
);

  typedef enum {LOCK_SEARCH, LOCK_HELD} lock_state_e;
  function automatic logic rising(input logic cur, input logic prev);
    return cur && !prev;
  endfunction

  // ****************************************************************
  // Serial receiver
  // ****************************************************************
  logic [WORD_BITS-1:0] word;
  logic word_valid;

  serial_shift_in u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .serial_clk_pin(serial_clk_pin),
    .serial_data_pin(serial_data_pin),
    .load_strobe_pin(load_strobe_pin),
    .word(word),
    .word_valid(word_valid)
  );

  // ****************************************************************
  // Latches
  // ****************************************************************
  logic [23:0] ctrl_reg, ctrl_next;
  logic [23:0] fb_reg, fb_next;
  logic [23:0] ref_reg, ref_next;
  logic cp_gain_reg, cp_gain_next;
  logic cp_oe_reg, cp_oe_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    fb_next = fb_reg;
    ref_next = ref_reg;
    cp_gain_next = cp_gain_reg;
    if (word_valid) begin
      case (word[SEL_LSB +: 2])
        SEL_CONTROL: begin
          ctrl_next = word;
          cp_gain_next = word[CTRL_CP_GAIN_BIT];
        end
        SEL_REFERENCE: ref_next = word;
        SEL_FEEDBACK: begin
          fb_next = word;
          cp_gain_next = word[FB_CP_GAIN_BIT];
        end
        default: ctrl_next = ctrl_reg;
      endcase
    end
    cp_oe_next = !ctrl_next[CP_TRISTATE_BIT];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      fb_reg <= FB_RESET;
      ref_reg <= REF_RESET;
      cp_gain_reg <= 1'b0;
      cp_oe_reg <= !CTRL_RESET[CP_TRISTATE_BIT];
    end else begin
      ctrl_reg <= ctrl_next;
      fb_reg <= fb_next;
      ref_reg <= ref_next;
      cp_gain_reg <= cp_gain_next;
      cp_oe_reg <= cp_oe_next;
    end
  end

  logic counters_held;
  logic [2:0] mux_sel;
  logic [REF_W-1:0] ref_count;
  logic [FB_W-1:0] fb_count;
  logic [1:0] band_div_sel;
  logic lock_fine;

  assign counters_held = ctrl_reg[COUNTER_RESET_BIT];
  assign mux_sel = ctrl_reg[MUX_SEL_LSB +: 3];
  assign ref_count = ref_reg[REF_COUNT_LSB +: REF_W];
  assign fb_count = fb_reg[FB_COUNT_LSB +: FB_W];
  assign band_div_sel = ref_reg[BAND_DIV_LSB +: 2];
  assign lock_fine = ref_reg[LOCK_PREC_BIT];
  assign cp_out_oe = cp_oe_reg;
  assign phase_polarity_sel = ctrl_reg[PHASE_POL_BIT];
  assign core_power_field = ctrl_reg[CORE_POWER_LSB +: 2];
  assign cp_gain_sel = cp_gain_reg;
  assign antibacklash_width_field = ref_reg[ABP_LSB +: 2];
  assign factory_test_sel = ref_reg[TEST_SEL_BIT];

  // ****************************************************************
  // Loop pin synchronisers
  // ****************************************************************
  logic [2:0] pin_meta_reg, pin_meta_next;
  logic [2:0] pin_sync_reg, pin_sync_next;
  logic [2:0] pin_prev_reg, pin_prev_next;

  always_comb begin
    pin_meta_next = {phase_ok_pin, vco_fb_pin, ref_in_pin};
    pin_sync_next = pin_meta_reg;
    pin_prev_next = pin_sync_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
      pin_prev_reg <= 3'h0;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
      pin_prev_reg <= pin_prev_next;
    end
  end
  logic ref_edge, fb_edge, phase_ok;
  assign ref_edge = rising(pin_sync_reg[0], pin_prev_reg[0]);
  assign fb_edge = rising(pin_sync_reg[1], pin_prev_reg[1]);
  assign phase_ok = pin_sync_reg[2];

  // ****************************************************************
  // Reference and feedback dividers
  // ****************************************************************
  logic [REF_W-1:0] ref_cnt_reg, ref_cnt_next;
  logic [FB_W-1:0] fb_cnt_reg, fb_cnt_next;
  logic ref_pulse_reg, ref_pulse_next;
  logic fb_pulse_reg, fb_pulse_next;

  always_comb begin
    ref_cnt_next = ref_cnt_reg;
    fb_cnt_next = fb_cnt_reg;
    ref_pulse_next = 1'b0;
    fb_pulse_next = 1'b0;
    if (counters_held) begin
      ref_cnt_next = '0;
      fb_cnt_next = '0;
    end else begin
      if (ref_edge) begin
        if (ref_cnt_reg + 1'b1 >= ref_count) begin
          ref_cnt_next = '0;
          ref_pulse_next = 1'b1;
        end else begin
          ref_cnt_next = REF_W'(ref_cnt_reg + 1'b1);
        end
      end
      if (fb_edge) begin
        if (fb_cnt_reg + 1'b1 >= fb_count) begin
          fb_cnt_next = '0;
          fb_pulse_next = 1'b1;
        end else begin
          fb_cnt_next = FB_W'(fb_cnt_reg + 1'b1);
        end
      end
    end
  end

  assign ref_div_pulse = ref_pulse_reg;
  assign fb_div_pulse = fb_pulse_reg;

  // ****************************************************************
  // Band select clock divider
  // ****************************************************************
  logic [2:0] band_cnt_reg, band_cnt_next;
  logic band_en_reg, band_en_next;
  logic [2:0] band_limit;

  always_comb begin
    band_limit = 3'((4'h1 << band_div_sel) - 4'h1);
    band_cnt_next = band_cnt_reg;
    band_en_next = 1'b0;
    if (counters_held) begin
      band_cnt_next = 3'h0;
    end else if (ref_pulse_reg) begin
      if (band_cnt_reg >= band_limit) begin
        band_cnt_next = 3'h0;
        band_en_next = 1'b1;
      end else begin
        band_cnt_next = band_cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_cnt_reg <= '0;
      fb_cnt_reg <= '0;
      ref_pulse_reg <= 1'b0;
      fb_pulse_reg <= 1'b0;
      band_cnt_reg <= 3'h0;
      band_en_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      fb_cnt_reg <= fb_cnt_next;
      ref_pulse_reg <= ref_pulse_next;
      fb_pulse_reg <= fb_pulse_next;
      band_cnt_reg <= band_cnt_next;
      band_en_reg <= band_en_next;
    end
  end

  assign band_clk_en = band_en_reg;

  // ****************************************************************
  // Lock detector
  // ****************************************************************
  lock_state_e lock_state_reg, lock_state_next;
  logic [2:0] good_cnt_reg, good_cnt_next;
  logic [2:0] lock_target;
  logic lock_reg, lock_next;

  always_comb begin
    lock_target = lock_fine ? LOCK_CYCLES_FINE : LOCK_CYCLES_COARSE;
    lock_state_next = lock_state_reg;
    good_cnt_next = good_cnt_reg;
    if (counters_held) begin
      lock_state_next = LOCK_SEARCH;
      good_cnt_next = 3'h0;
    end else if (ref_pulse_reg) begin
      case (lock_state_reg)
        LOCK_SEARCH: begin
          if (!phase_ok) begin
            good_cnt_next = 3'h0;
          end else if (good_cnt_reg + 3'h1 >= lock_target) begin
            good_cnt_next = 3'h0;
            lock_state_next = LOCK_HELD;
          end else begin
            good_cnt_next = good_cnt_reg + 3'h1;
          end
        end
        LOCK_HELD: lock_state_next = phase_ok ? LOCK_HELD : LOCK_SEARCH;
        default: lock_state_next = LOCK_SEARCH;
      endcase
    end
    lock_next = (lock_state_next == LOCK_HELD);
  end

  assign lock_detect = lock_reg;

  // ****************************************************************
  // Multiplexed output
  // ****************************************************************
  logic mux_reg, mux_next;

  always_comb begin
    case (mux_sel)
      MUX_LOCK: mux_next = lock_detect;
      MUX_REF_DIV: mux_next = ref_pulse_reg;
      MUX_FB_DIV: mux_next = fb_pulse_reg;
      MUX_BAND_CLK: mux_next = band_en_reg;
      MUX_HIGH: mux_next = 1'b1;
      MUX_HELD: mux_next = counters_held;
      default: mux_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_state_reg <= LOCK_SEARCH;
      good_cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
      mux_reg <= 1'b0;
    end else begin
      lock_state_reg <= lock_state_next;
      good_cnt_reg <= good_cnt_next;
      lock_reg <= lock_next;
      mux_reg <= mux_next;
    end
  end

  assign multiplexed_output_pin = mux_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence load_of(logic [1:0] code);
    word_valid && (word[SEL_LSB +: 2] == code);
  endsequence
  AST_CTRL_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_CONTROL) |=> ctrl_reg == $past(word)) else $error("control word not loaded");
  AST_TRISTATE: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_CONTROL) |=> cp_out_oe == !$past(word[CP_TRISTATE_BIT]))
    else $error("charge pump enable does not follow three-state bit");
  AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_CONTROL) |=> phase_polarity_sel == $past(word[PHASE_POL_BIT]))
    else $error("phase polarity not taken from control word");
  AST_MUX_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (mux_sel == MUX_LOCK) && $stable(mux_sel) |-> multiplexed_output_pin == $past(lock_detect))
    else $error("mux output does not show lock state");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    counters_held ##1 counters_held |-> ref_cnt_reg == '0 && !ref_div_pulse && !lock_detect)
    else $error("counters run while held in reset");
  AST_REF_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_REFERENCE) |=> ref_reg == $past(word) && $stable(ctrl_reg))
    else $error("reference latch not loaded alone");
  AST_FB_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_FEEDBACK) |=> fb_reg == $past(word) && cp_gain_sel == $past(word[FB_CP_GAIN_BIT]))
    else $error("feedback latch or gain not loaded");
  AST_TEST_IGNORED: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_TEST) |=> $stable(ctrl_reg) && $stable(fb_reg) && $stable(ref_reg))
    else $error("test latch code disturbed a latch");
  AST_GAIN_LATEST: assert property (@(posedge clk) disable iff (!rst_n)
    load_of(SEL_CONTROL) ##1 !word_valid [*2] |-> cp_gain_sel == $past(word[CTRL_CP_GAIN_BIT], 2))
    else $error("charge pump gain not from latest control write");
  AST_LOCK_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lock_detect) |-> $past(good_cnt_reg) + 3'h1 == $past(lock_target))
    else $error("lock declared after wrong number of cycles");

endmodule

`default_nettype wire

/* File: verification/host_serial_model.sv */
// Purpose: Host side of the three-wire link; sends 24-bit words to the latch bank.
// Assumes: Pins change on the falling edge of clk, each level held two or more cycles.
// Notes: The serial clock stands low outside frames; the data line toggles after the last bit.
`default_nettype none

module host_serial_model (
  // Clock
  input wire logic clk,
  // Serial pins toward the device
  output var logic serial_clk_pin,
  output var logic serial_data_pin,
  output var logic load_strobe_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_clk_pin = 1'b0;
    serial_data_pin = 1'b0;
    load_strobe_pin = 1'b0;
  end

  // ****************************************************************
  // One frame: strobe low, 24 bits, strobe rise
  // ****************************************************************
  task automatic send_word(input logic [23:0] w);
    @(negedge clk);
    load_strobe_pin = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk);
      serial_data_pin = w[i];
      serial_clk_pin = 1'b0;
      repeat (2) @(negedge clk);
      serial_clk_pin = 1'b1;
      repeat (3) @(negedge clk);
    end
    serial_clk_pin = 1'b0;
    serial_data_pin = ~serial_data_pin;
    repeat (3) @(negedge clk);
    load_strobe_pin = 1'b1;
  endtask
endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the synthesizer latch bank.
// Assumes: Outputs settle within eight cycles of a strobe rise or loop edge.
// Notes: Expected vectors are queued; a monitor compares them on check requests.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_pkg::*;

  logic clk, rst_n, ref_in_pin, vco_fb_pin, phase_ok_pin, chk_req;
  logic sclk, sdata, strobe;
  logic cp_out_oe, phase_polarity_sel, cp_gain_sel, factory_test_sel;
  logic [1:0] antibacklash_width_field, core_power_field;
  logic ref_div_pulse, fb_div_pulse, band_clk_en, lock_detect, multiplexed_output_pin;
  logic [23:0] ctrl, fb, rf;
  logic gain, lock;
  logic [33:0] exp_q[$];
  logic [33:0] exp_v, seen_v;
  int ref_ph, fb_ph, band_ph, consec, exp_ref, exp_fb, exp_band;
  int seen_ref, seen_fb, seen_band, miscompares, total_checks, cycles, seed;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  host_serial_model host (
    .clk(clk),
    .serial_clk_pin(sclk),
    .serial_data_pin(sdata),
    .load_strobe_pin(strobe)
  );

  synth_serial_latch_bank i_synth_serial_latch_bank (
    .clk(clk),
    .rst_n(rst_n),
    .serial_clk_pin(sclk),
    .serial_data_pin(sdata),
    .load_strobe_pin(strobe),
    .ref_in_pin(ref_in_pin),
    .vco_fb_pin(vco_fb_pin),
    .phase_ok_pin(phase_ok_pin),
    .cp_out_oe(cp_out_oe),
    .phase_polarity_sel(phase_polarity_sel),
    .cp_gain_sel(cp_gain_sel),
    .antibacklash_width_field(antibacklash_width_field),
    .core_power_field(core_power_field),
    .factory_test_sel(factory_test_sel),
    .ref_div_pulse(ref_div_pulse),
    .fb_div_pulse(fb_div_pulse),
    .band_clk_en(band_clk_en),
    .lock_detect(lock_detect),
    .multiplexed_output_pin(multiplexed_output_pin)
  );

  // ****************************************************************
  // Expected outputs and pulse counts since the last check
  // ****************************************************************
  function automatic logic [33:0] exp_vec();
    logic pin;
    case (ctrl[7:5])
      3'h1: pin = lock;
      3'h5: pin = 1'b1;
      3'h6: pin = ctrl[4];
      default: pin = 1'b0;
    endcase
    return {~ctrl[9], ctrl[8], gain, rf[17:16], ctrl[3:2], rf[19], lock, pin,
            8'(exp_ref), 8'(exp_fb), 8'(exp_band)};
  endfunction

  task automatic check();
    exp_q.push_back(exp_vec());
    exp_ref = 0;
    exp_fb = 0;
    exp_band = 0;
    chk_req = 1'b1;
    @(negedge clk);
    chk_req = 1'b0;
  endtask

  task automatic write_word(input logic [23:0] w);
    host.send_word(w);
    case (w[1:0])
      2'h0: begin
        ctrl = w;
        gain = w[10];
      end
      2'h1: rf = w;
      2'h2: begin
        fb = w;
        gain = w[21];
      end
      default: ;
    endcase
    if (ctrl[4]) begin
      ref_ph = 0;
      fb_ph = 0;
      band_ph = 0;
      consec = 0;
      lock = 1'b0;
    end
    repeat (8) @(negedge clk);
    check();
  endtask

  function automatic logic [23:0] rand_word(input int i);
    logic [23:0] w;
    w = 24'($urandom);
    w[1:0] = 2'(i % 4);
    case (w[1:0])
      2'h0: w[7:5] = 3'(i / 4);
      2'h1: begin
        w[23:22] = 2'h0;
        w[19] = 1'b0;
      end
      2'h2: begin
        w[7:2] = 6'h0;
        if (w[20:8] < 13'h3) w[20:8] = 13'h3;
      end
      default: ;
    endcase
    return w;
  endfunction

  // Drives n edges on both loop inputs and steps the divider and lock model
  task automatic loop_edges(input int n, input logic ok);
    phase_ok_pin = ok;
    repeat (n) begin
      repeat (4) @(negedge clk);
      ref_in_pin = 1'b1;
      vco_fb_pin = 1'b1;
      repeat (4) @(negedge clk);
      ref_in_pin = 1'b0;
      vco_fb_pin = 1'b0;
      if (!ctrl[4]) begin
        ref_ph++;
        fb_ph++;
        if (fb_ph >= int'(fb[20:8])) begin
          fb_ph = 0;
          exp_fb++;
        end
        if (ref_ph >= int'(rf[15:2])) begin
          ref_ph = 0;
          exp_ref++;
          band_ph++;
          if (ok) consec++;
          else begin
            consec = 0;
            lock = 1'b0;
          end
          if (consec >= (rf[18] ? 5 : 3)) lock = 1'b1;
          if (band_ph >= (1 << rf[21:20])) begin
            band_ph = 0;
            exp_band++;
          end
        end
      end
    end
    repeat (8) @(negedge clk);
    check();
  endtask

  // ****************************************************************
  // Monitor
  // ****************************************************************
  always @(posedge clk) begin
    if (ref_div_pulse === 1'b1) seen_ref++;
    if (fb_div_pulse === 1'b1) seen_fb++;
    if (band_clk_en === 1'b1) seen_band++;
    if (chk_req === 1'b1) begin
      exp_v = exp_q.pop_front();
      seen_v = {cp_out_oe, phase_polarity_sel, cp_gain_sel, antibacklash_width_field,
                core_power_field, factory_test_sel, lock_detect, multiplexed_output_pin,
                8'(seen_ref), 8'(seen_fb), 8'(seen_band)};
      total_checks++;
      if (seen_v !== exp_v) begin
        miscompares++;
        $display("Error outputs expected %h seen %h", exp_v, seen_v);
      end
      seen_ref = 0;
      seen_fb = 0;
      seen_band = 0;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    ref_in_pin = 1'b0;
    vco_fb_pin = 1'b0;
    phase_ok_pin = 1'b0;
    chk_req = 1'b0;
    seed = $urandom(35);
    ctrl = CTRL_RESET;
    fb = FB_RESET;
    rf = REF_RESET;
    gain = 1'b0;
    lock = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    check();
    for (int i = 0; i < 32; i++) write_word(rand_word(i));
    write_word({4'h1, 2'h1, 2'h2, 14'h3, 2'h1});
    write_word({2'h0, 1'b1, 13'h3, 6'h0, 2'h2});
    write_word({13'h0, 1'b0, 1'b0, 1'b1, 3'h1, 1'b0, 2'h1, 2'h0});
    loop_edges(12, 1'b1);
    loop_edges(3, 1'b1);
    loop_edges(3, 1'b0);
    write_word({4'h0, 2'h0, 2'h1, 14'h3, 2'h1});
    loop_edges(6, 1'b1);
    loop_edges(3, 1'b1);
    write_word({13'h0, 1'b1, 1'b1, 1'b0, 3'h6, 1'b1, 2'h2, 2'h0});
    loop_edges(3, 1'b1);
    finish_test();
  end
endmodule

`default_nettype wire
